// *** include/rt_opt_defs.vh ***
// Constants for the remote-terminal ping-pong and message-interrupt option block
`ifndef RT_OPT_DEFS_VH
`define RT_OPT_DEFS_VH

// Register word addresses
`define ADDR_W              8
`define OFF_PENDING         8'h09
`define OFF_IRQ_ENABLE      8'h12
`define OFF_IRQ_OUT_ENABLE  8'h16
`define OFF_OPTION          8'h4D

// Reset values
`define RST_OPTION          16'h0000
`define RST_IRQ_ENABLE      16'h0000
`define RST_IRQ_OUT_ENABLE  16'h0000
`define RST_PENDING         16'h0000

// Option register fields
`define OPT_IRQ_SUPPRESS    0
`define OPT_TOGGLE_HOLD     1
`define OPT_MASK            16'h0003

// Interrupt type bit positions (pending, enable, output enable, log word)
`define IRQ_TYPES           3
`define IRQ_MSG_ERROR       0
`define IRQ_ACCESSED        1
`define IRQ_BROADCAST       2

// Descriptor control word fields
`define CW_BUF_SELECT       10
`define CW_EN_MSG_ERROR     4
`define CW_EN_ACCESSED      5
`define CW_EN_BROADCAST     6

// Message information word status flags
`define MIW_MSG_ERROR       10
`define MIW_BUSY            9
`define MIW_ILLEGAL         8

`endif

// *** verification/rt_msg_engine.sv ***
// Far-side message engine holding the descriptor word
`timescale 1ns/1ps
`default_nettype none
module rt_msg_engine (
	input wire logic i_clk, i_rst_n, i_go, i_ctrl_wr,
	input wire logic [6:0] i_kind,
	input wire logic [15:0] i_ctrl_in,
	output logic o_done,
	output logic [6:0] o_kind,
	output logic [15:0] o_cw
);
	// Qualifiers flip between messages so stale values are never usable
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n) {o_done, o_kind, o_cw} <= {8'h00, 16'h0070};
		else begin
			o_done <= i_go;
			o_kind <= i_go ? i_kind : ~o_kind;
			if (i_ctrl_wr) o_cw <= i_ctrl_in;
		end
endmodule // rt_msg_engine
`default_nettype wire

// *** verification/rt_pingpong_irq_options_asserts.sv ***
// Checker for pointer and interrupt pin behaviour
`timescale 1ns/1ps
`default_nettype none
module rt_opt_chk (
	input wire logic i_clk, i_rst_n, i_wr, i_rd, i_msg_done, i_pingpong, i_mixed_wc,
	input wire logic i_wc_legal, i_illegal, i_msg_error, i_busy, o_buf_sel, o_data_wr_en,
	input wire logic o_info_wr, o_log_wr, o_irq_n, o_ttag_wr, o_ctrl_wr,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wr_data, o_rd_data, i_ctrl_word, o_ctrl_word, o_info_word,
	input wire logic [15:0] o_log_word
);
	logic [1:0] opt;
	logic [2:0] en;
	wire ok = ~i_mixed_wc | i_wc_legal;
	wire bad = i_illegal | i_msg_error | i_busy;
	wire next_ptr = i_ctrl_word[10] ^ (ok & (~bad | ~opt[1]));
	wire [2:0] st = {i_msg_error, i_busy, i_illegal};
	wire pin_ok = i_msg_done & ok & ~(opt[0] & (i_illegal | i_busy));
	// Option bits are not a port, so writes are shadowed
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n) {opt, en} <= 5'h00;
		else if (i_wr && i_addr == 8'h4D) opt <= i_wr_data[1:0];
		else if (i_wr && i_addr == 8'h12) en <= i_wr_data[2:0];
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	a_buf_select: assert property (i_msg_done && i_pingpong |=>
		o_buf_sel == $past(i_ctrl_word[10])) else $error("buffer");
	a_ptr_toggle: assert property (i_msg_done && i_pingpong |=>
		o_ctrl_word[10] == $past(next_ptr)) else $error("toggle");
	a_data_hold: assert property (i_msg_done && bad |=> !o_data_wr_en) else $error("data");
	a_info_write: assert property (i_msg_done |=> o_info_wr) else $error("info");
	a_info_flags: assert property (i_msg_done |=>
		o_info_word[10:8] == $past(st)) else $error("flags");
	a_opt_read: assert property (i_rd && i_addr == 8'h4D |=>
		o_rd_data == {14'h0, $past(opt)}) else $error("option");
	a_pin_cause: assert property ($fell(o_irq_n) && !$past(i_wr) |->
		$past(pin_ok)) else $error("pin");
	a_log_count: assert property (i_msg_done && !ok |=> !o_log_wr) else $error("log");
	a_ttag_write: assert property (i_msg_done |=> o_ttag_wr) else $error("ttag");
	a_data_good: assert property (i_msg_done && !bad |=> o_data_wr_en) else $error("good");
	a_ctrl_write: assert property (i_msg_done && i_pingpong |=> o_ctrl_wr) else $error("ctrl");
	a_log_access: assert property (i_msg_done && ok && i_ctrl_word[5] && en[1] |=>
		o_log_wr && o_log_word[1]) else $error("access");
endmodule // rt_opt_chk
bind rt_pingpong_irq_options rt_opt_chk rt_opt_chk_inst (.*);
`default_nettype wire

// *** verification/rt_pingpong_irq_options_bench.sv ***
// Bench for the option block
`timescale 1ns/1ps
`default_nettype none
module rt_pingpong_irq_options_bench;
	logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, go = 0, ptr = 0;
	logic [7:0] i_addr = 8'h00;
	logic [15:0] i_wr_data = 16'h0000, i_info_word = 16'h00FF, d;
	logic [6:0] kind = 7'h00;
	logic [1:0] opt = 2'h0;
	int mismatches = 0, compares = 0, n;
	wire i_msg_done, i_pingpong, i_mixed_wc, i_wc_legal, i_illegal, i_msg_error, i_busy;
	wire i_broadcast, o_ctrl_wr, o_buf_sel, o_data_wr_en, o_info_wr, o_ttag_wr, o_log_wr, o_irq_n;
	wire [15:0] i_ctrl_word, o_rd_data, o_ctrl_word, o_info_word, o_log_word;
	always #10 i_clk = ~i_clk;
	rt_pingpong_irq_options rt_pingpong_irq_options_inst (.*);
	rt_msg_engine rt_msg_engine_inst (.i_clk, .i_rst_n, .i_go(go), .i_ctrl_wr(o_ctrl_wr),
		.i_kind(kind), .i_ctrl_in(o_ctrl_word), .o_done(i_msg_done), .o_cw(i_ctrl_word),
		.o_kind({i_pingpong, i_mixed_wc, i_wc_legal, i_illegal, i_msg_error, i_busy, i_broadcast}));
	task automatic chk(input logic [15:0] got, exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] v);
		@(posedge i_clk);
		{i_wr, i_rd} <= {w, !w};
		i_addr <= a;
		i_wr_data <= v;
		@(posedge i_clk);
		{i_wr, i_rd} <= 2'h0;
		#1 d = o_rd_data;
	endtask
	task automatic msg(input logic [6:0] m);
		@(posedge i_clk);
		{go, kind} <= {1'b1, m};
		@(posedge i_clk);
		go <= 0;
		repeat (2) @(posedge i_clk);
		// Pointer moves only on write-back, so it is checked after that edge
		if (m[6] & (~m[5] | m[4]) & (~|m[3:1] | ~opt[1])) ptr = ~ptr;
		#1 chk(i_ctrl_word[10], ptr);
		chk(o_info_word, {5'h00, m[2], m[1], m[3], 8'hFF});
		chk(o_log_word, (~m[5] | m[4]) ? {13'h0, m[0], 1'b1, m[2]} : 16'h0000);
	endtask
	task automatic stop_test;
		$display("mismatches=%0d compares=%0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		n = $urandom(25);
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1;
		bus(0, 8'h4D, 16'h0000);
		chk(d, 16'h0000);
		bus(1, 8'h4D, 16'hFFFF);
		opt = 2'h3;
		bus(1, 8'h12, 16'h0007);
		bus(1, 8'h16, 16'h0007);
		msg(7'h56);
		chk(o_irq_n, 1);
		bus(0, 8'h09, 16'h0000);
		chk(d, 16'h0003);
		bus(1, 8'h09, 16'h0007);
		msg(7'h54);
		chk(o_irq_n, 0);
		bus(1, 8'h16, 16'h0000);
		chk(o_irq_n, 1);
		for (n = 0; n < 300; n++) begin
			opt = ($urandom % 3 == 0) ? 2'($urandom) : opt;
			bus(1, 8'h4D, {14'h0, opt});
			if (n % 8 == 0) bus(1, 8'h09, 16'h0007);
			if (n % 8 == 4) bus(1, 8'h16, 16'($urandom % 8));
			msg(7'($urandom));
		end
		stop_test;
	end
	initial begin
		#200us;
		mismatches++;
		stop_test;
	end
endmodule // rt_pingpong_irq_options_bench
`default_nettype wire

// *** verilog/rt_pingpong_irq_options.v ***
// Ping-pong buffer pointer control and RT message interrupt gating
// Operation
// R1: Ping-pong subaddress alternates buffers A and B
// R2: Control word bit 10 selects next buffer
// R3: Hold option stops toggle on bad messages
// R4: Held pointer waits for next successful message
// R5: Mixed word-count subaddress toggles only legal counts
// R6: Incomplete messages leave buffer data untouched
// R7: Incomplete messages still update info and tag
// R8: Info word bits 10:8 flag error/busy/illegal
// R9: Host ignores data when status flags set
// R10: With hold, inverted pointer marks last good
// R11: Option register resets to 0x0000
// R12: Without hold, toggle after every message
// R13: Interrupts enabled globally and per descriptor
// R14: Enabled event sets pending bit, logs entry
// R15: Pin asserts only if output enable set
// R16: Suppress option gates pin for illegal/busy
// R17: Mixed word-count subaddress interrupts only legal counts
// R18: Suppression gates pin only, still records
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rt_opt_defs.vh"

module rt_pingpong_irq_options (
	// Clock and reset
	input  wire                   i_clk,
	input  wire                   i_rst_n,
	// Register port
	input  wire [`ADDR_W-1:0]     i_addr,
	input  wire [15:0]            i_wr_data,
	input  wire                   i_wr,
	input  wire                   i_rd,
	output reg  [15:0]            o_rd_data,
	// Message completion from the protocol engine
	input  wire                   i_msg_done,
	input  wire                   i_pingpong,
	input  wire                   i_mixed_wc,
	input  wire                   i_wc_legal,
	input  wire                   i_illegal,
	input  wire                   i_msg_error,
	input  wire                   i_busy,
	input  wire                   i_broadcast,
	input  wire [15:0]            i_ctrl_word,
	input  wire [15:0]            i_info_word,
	// Buffer and descriptor write-back
	output reg                    o_ctrl_wr,
	output reg  [15:0]            o_ctrl_word,
	output reg                    o_buf_sel,
	output reg                    o_data_wr_en,
	output reg                    o_info_wr,
	output reg  [15:0]            o_info_word,
	output reg                    o_ttag_wr,
	// Interrupt log and pin
	output reg                    o_log_wr,
	output reg  [15:0]            o_log_word,
	output wire                   o_irq_n
);

	// Register state
	reg  [15:0]                   option;
	reg  [15:0]                   irq_enable;
	reg  [15:0]                   irq_out_enable;
	reg  [`IRQ_TYPES-1:0]         pending;
	reg  [`IRQ_TYPES-1:0]         pin_pending;

	// Next values of the registered outputs and the pending bits
	reg  [15:0]                   next_rd_data;
	reg  [15:0]                   next_ctrl_word;
	reg                           next_buf_sel;
	reg  [15:0]                   next_info_word;
	reg  [15:0]                   next_log_word;
	reg  [`IRQ_TYPES-1:0]         next_pending;
	reg  [`IRQ_TYPES-1:0]         next_pin_pending;

	// Message classes; illegal outranks busy, busy outranks error
	localparam [1:0]              CLS_GOOD    = 2'h0;
	localparam [1:0]              CLS_ILLEGAL = 2'h1;
	localparam [1:0]              CLS_BUSY    = 2'h2;
	localparam [1:0]              CLS_ERROR   = 2'h3;

	// Message decode
	reg  [1:0]                    msg_class;
	reg                           class_good;
	reg                           class_reject;
	wire                          good_msg;
	wire                          wc_ok;
	wire                          hold;
	wire                          toggle;
	wire                          suppress;
	wire                          wr_option;
	wire                          wr_irq_enable;
	wire                          wr_irq_out_enable;
	wire                          wr_pending;
	wire [`IRQ_TYPES-1:0]         event_vec;
	wire [`IRQ_TYPES-1:0]         clear_vec;
	wire [`IRQ_TYPES-1:0]         set_vec;
	wire [`IRQ_TYPES-1:0]         pin_set_vec;
	wire [`IRQ_TYPES-1:0]         pin_route;
	wire [15:0]                   toggle_mask;
	genvar                        g;

	// Address match, used by the register write decodes only
	function hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// Event vector from descriptor enables, global enables and status
	function [`IRQ_TYPES-1:0] events;
		input [15:0] cw;
		input [15:0] glob;
		input        err;
		input        bcast;
		begin
			events = {`IRQ_TYPES{1'b0}};
			events[`IRQ_MSG_ERROR] = err & cw[`CW_EN_MSG_ERROR] & glob[`IRQ_MSG_ERROR];
			events[`IRQ_ACCESSED]  = cw[`CW_EN_ACCESSED] & glob[`IRQ_ACCESSED];
			events[`IRQ_BROADCAST] = bcast & cw[`CW_EN_BROADCAST] & glob[`IRQ_BROADCAST];
		end
	endfunction

	// Classify once so pointer, data and pin agree on what went wrong
	always @* begin
		if (i_illegal) begin
			msg_class = CLS_ILLEGAL;
		end else if (i_busy) begin
			msg_class = CLS_BUSY;
		end else if (i_msg_error) begin
			msg_class = CLS_ERROR;
		end else begin
			msg_class = CLS_GOOD;
		end
	end

	always @* begin
		class_good   = 1'b0;
		class_reject = 1'b0;
		case (msg_class)
			CLS_GOOD: begin
				class_good = 1'b1;
			end
			CLS_ILLEGAL, CLS_BUSY: begin
				class_reject = 1'b1;
			end
			CLS_ERROR: begin
				class_reject = 1'b0;
			end
			default: begin
				class_good   = 1'b0;
				class_reject = 1'b0;
			end
		endcase
	end

	assign good_msg = class_good;
	// A mixed subaddress counts a message only when its word count is supported
	assign wc_ok    = ~i_mixed_wc | i_wc_legal;                           // R5
	assign hold     = option[`OPT_TOGGLE_HOLD];
	// Hold keeps the pointer on the last good buffer's complement
	assign toggle   = i_pingpong & wc_ok & (good_msg | ~hold);           // R1 R3 R4 R10 R12
	assign suppress = option[`OPT_IRQ_SUPPRESS] & class_reject;         // R16

	// Register write decodes
	assign wr_option         = i_wr & hit(i_addr, `OFF_OPTION);
	assign wr_irq_enable     = i_wr & hit(i_addr, `OFF_IRQ_ENABLE);
	assign wr_irq_out_enable = i_wr & hit(i_addr, `OFF_IRQ_OUT_ENABLE);
	assign wr_pending        = i_wr & hit(i_addr, `OFF_PENDING);

	// Only the pointer bit of the descriptor may change
	assign toggle_mask = {{(15-`CW_BUF_SELECT){1'b0}}, toggle, {`CW_BUF_SELECT{1'b0}}};

	// Only messages with a usable word count raise interrupt events
	assign event_vec = (i_msg_done & wc_ok) ?
		events(i_ctrl_word, irq_enable, i_msg_error, i_broadcast) :
		{`IRQ_TYPES{1'b0}};                                               // R13 R17
	assign set_vec     = event_vec;                                      // R14
	assign clear_vec   = wr_pending ?
		i_wr_data[`IRQ_TYPES-1:0] : {`IRQ_TYPES{1'b0}};

	// Suppressed events are still recorded, only the pin path drops them
	generate
		for (g = 0; g < `IRQ_TYPES; g = g + 1) begin : gen_pin_set
			assign pin_set_vec[g] = event_vec[g] & ~suppress;            // R16 R18
		end
	endgenerate

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			option <= `RST_OPTION;                                       // R11
		end else if (wr_option) begin
			option <= i_wr_data & `OPT_MASK;
		end
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_enable <= `RST_IRQ_ENABLE;
		end else if (wr_irq_enable) begin
			irq_enable <= i_wr_data;
		end
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_out_enable <= `RST_IRQ_OUT_ENABLE;
		end else if (wr_irq_out_enable) begin
			irq_out_enable <= i_wr_data;
		end
	end

	// Pending bits: write one to clear, a new event in the same cycle wins
	generate
		for (g = 0; g < `IRQ_TYPES; g = g + 1) begin : gen_pending
			always @* begin
				next_pending[g] = pending[g];
				if (set_vec[g]) begin
					next_pending[g] = 1'b1;                              // R14
				end else if (clear_vec[g]) begin
					next_pending[g] = 1'b0;
				end
			end
			always @* begin
				next_pin_pending[g] = pin_pending[g];
				if (pin_set_vec[g]) begin
					next_pin_pending[g] = 1'b1;                          // R18
				end else if (clear_vec[g]) begin
					next_pin_pending[g] = 1'b0;
				end
			end
			always @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					pending[g]     <= 1'b0;
					pin_pending[g] <= 1'b0;
				end else begin
					pending[g]     <= next_pending[g];
					pin_pending[g] <= next_pin_pending[g];
				end
			end
		end
	endgenerate

	always @* begin
		next_ctrl_word = o_ctrl_word;
		next_buf_sel   = o_buf_sel;
		if (i_msg_done) begin
			next_ctrl_word = i_ctrl_word ^ toggle_mask;                  // R1 R12
			next_buf_sel   = i_pingpong & i_ctrl_word[`CW_BUF_SELECT];   // R2
		end
	end

	// Info word carries the three status flags for the host
	always @* begin
		next_info_word = o_info_word;
		if (i_msg_done) begin
			next_info_word                 = i_info_word;
			next_info_word[`MIW_MSG_ERROR] = i_msg_error;                // R8
			next_info_word[`MIW_BUSY]      = i_busy;                     // R8
			next_info_word[`MIW_ILLEGAL]   = i_illegal;                  // R8
		end
	end

	always @* begin
		next_log_word = o_log_word;
		if (i_msg_done) begin
			next_log_word = {{(16-`IRQ_TYPES){1'b0}}, event_vec};        // R14
		end
	end

	// Read mux; unmapped addresses read zero so probing is harmless
	always @* begin
		next_rd_data = 16'h0000;
		if (i_rd) begin
			case (i_addr)
				`OFF_OPTION: begin
					next_rd_data = option;
				end
				`OFF_IRQ_ENABLE: begin
					next_rd_data = irq_enable;
				end
				`OFF_IRQ_OUT_ENABLE: begin
					next_rd_data = irq_out_enable;
				end
				`OFF_PENDING: begin
					next_rd_data = {{(16-`IRQ_TYPES){1'b0}}, pending};
				end
				default: begin
					next_rd_data = 16'h0000;
				end
			endcase
		end
	end

	// Write-back strobes, at most one cycle each per completed message
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ctrl_wr    <= 1'b0;
			o_data_wr_en <= 1'b0;
			o_info_wr    <= 1'b0;
			o_ttag_wr    <= 1'b0;
			o_log_wr     <= 1'b0;
		end else begin
			o_ctrl_wr    <= i_msg_done & i_pingpong;                     // R1
			o_data_wr_en <= i_msg_done & good_msg;                       // R6
			o_info_wr    <= i_msg_done;                                  // R7
			o_ttag_wr    <= i_msg_done;                                  // R7
			o_log_wr     <= |event_vec;                                  // R14 R18
		end
	end

	// Data words hold until the next message so the far side may take them late
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ctrl_word <= 16'h0000;
			o_buf_sel   <= 1'b0;
			o_info_word <= 16'h0000;
			o_log_word  <= 16'h0000;
		end else begin
			o_ctrl_word <= next_ctrl_word;
			o_buf_sel   <= next_buf_sel;
			o_info_word <= next_info_word;
			o_log_word  <= next_log_word;
		end
	end

	// Read data stands for one cycle only
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= 16'h0000;
		end else begin
			o_rd_data <= next_rd_data;
		end
	end

	// Pin follows pending events that were not suppressed and are routed out
	assign pin_route = pin_pending & irq_out_enable[`IRQ_TYPES-1:0];    // R15
	assign o_irq_n   = ~|pin_route;

endmodule // rt_pingpong_irq_options

`default_nettype wire
